// [hdl/hap_pkg.sv]
// Purpose: Shared constants and types for the host access port
// Assumes: 32-bit internal memory space, byte addressed
// Notes: Control register bit positions are local to this port
package hap_pkg;
    // Access types chosen by the host's two type pins
    localparam logic [1:0] HAP_TYPE_CTRL = 2'h0;
    localparam logic [1:0] HAP_TYPE_INC = 2'h1;
    localparam logic [1:0] HAP_TYPE_ADDR = 2'h2;
    localparam logic [1:0] HAP_TYPE_NOINC = 2'h3;

    // Control register layout and reset values
    localparam int HAP_CTRL_CORE_INT_BIT = 1;
    localparam int HAP_CTRL_HOST_INT_BIT = 2;
    localparam logic [31:0] HAP_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] HAP_DATA_RESET = 32'h0000_0000;
    localparam logic [15:0] HAP_HALF_RESET = 16'h0000;
    localparam logic [1:0] HAP_BE2_RESET = 2'h0;
    localparam logic [3:0] HAP_BE4_RESET = 4'h0;

    // One auto-increment step is one 32-bit word
    localparam logic [31:0] HAP_WORD_STEP = 32'h0000_0004;

    // Synchroniser bundle: chip select, strobes, rw, type, be, addr pins, data
    localparam int HAP_SYNC_W = 58;
    localparam logic [57:0] HAP_SYNC_RST = 58'h200_0000_0000_0000;

    typedef enum logic [1:0] {
        HAP_MODE_MUX_HALF = 2'b00,
        HAP_MODE_MUX_FULL = 2'b01,
        HAP_MODE_NONMUX = 2'b10
    } hap_mode_t;

    typedef enum logic [1:0] {
        HAP_ST_IDLE = 2'b00,
        HAP_ST_READ = 2'b01,
        HAP_ST_WRITE = 2'b10
    } hap_state_t;
endpackage

// [hdl/hap_sync.sv]
// Purpose: Two-flop synchroniser for the host pin bundle
// Assumes: Each bit is sampled on its own; pins are held around strobe edges
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module hap_sync
    import hap_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] syncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_reg;

    // Two stages to settle metastability
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_reg <= syncIn;
            syncOut <= meta_reg;
        end
    end
endmodule

// [hdl/hap_port.sv]
// Purpose: Host parallel access port into the device memory space
// Assumes: Host pins are asynchronous; config and memory ports share clk
// Notes: Host must wait on ready before starting a new access
`timescale 1ns/1ps
module hap_port
    import hap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hostChipSelect_b,
    input wire logic [1:0] hostDataStrobes,
    input wire logic hostReadWrite,
    input wire logic [1:0] accessTypeSelect,
    input wire logic [3:0] hostByteEnables,
    input wire logic [15:0] hostAddrPins,
    input wire logic [31:0] hostDataIn,
    output logic [31:0] hostDataOut,
    output logic hostDataOe,
    output logic hostReadyOut,
    output logic interruptToHost,
    output logic hostToCoreInt,
    input wire logic coreHostIntSet,
    input wire logic coreIntClear,
    input wire logic nonmuxModeBit,
    input wire logic fullwordModeBit,
    input wire logic pageRestrictBit,
    input wire logic [7:0] pageAddrTopByte,
    input wire logic [7:0] pageAddrUpperMidByte,
    output logic memReq,
    output logic memWrite,
    output logic [31:0] memAddr,
    output logic [3:0] memByteEn,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    logic [HAP_SYNC_W-1:0] pinsS;
    logic csS_b;
    logic [1:0] dsS;
    logic rwS;
    logic [1:0] typeS;
    logic [3:0] beS;
    logic [15:0] addrPinS;
    logic [31:0] dataS;
    logic strobeActive;
    logic strobePrev_reg;
    logic strobeFall;
    logic strobeRise;
    hap_mode_t mode;
    hap_state_t state_reg;
    hap_state_t stateNext;
    logic [1:0] typeLat_reg;
    logic rwLat_reg;
    logic hwilLat_reg;
    logic [3:0] beLat_reg;
    logic [15:0] addrLat_reg;
    logic [15:0] halfBuf_reg;
    logic [1:0] beBuf_reg;
    logic [31:0] rdBuf_reg;
    logic [31:0] portAddr_reg;
    logic [31:0] dataOut_reg;
    logic dataOe_reg;
    logic ready_reg;
    logic hostInt_reg;
    logic coreInt_reg;
    logic memReq_reg;
    logic memWrite_reg;
    logic [31:0] memAddr_reg;
    logic [3:0] memBe_reg;
    logic [31:0] memWdata_reg;
    logic liveIsData;
    logic liveOk;
    logic latIsData;
    logic latOk;
    logic startRead;
    logic wrAct;
    logic startWrite;
    logic [31:0] wrWord;
    logic [3:0] wrBe;
    logic [31:0] ctrlView;

    // Every host pin crosses into clk through two flops
    hap_sync #(
        .W(HAP_SYNC_W),
        .RST_VAL(HAP_SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .syncIn({hostChipSelect_b, hostDataStrobes, hostReadWrite, accessTypeSelect,
                 hostByteEnables, hostAddrPins, hostDataIn}),
        .syncOut(pinsS)
    );

    assign csS_b = pinsS[57];
    assign dsS = pinsS[56:55];
    assign rwS = pinsS[54];
    assign typeS = pinsS[53:52];
    assign beS = pinsS[51:48];
    assign addrPinS = pinsS[47:32];
    assign dataS = pinsS[31:0];

    // One strobe: select low and the two strobes unequal
    assign strobeActive = !csS_b && (dsS[0] ^ dsS[1]);
    assign strobeFall = strobeActive && !strobePrev_reg;
    assign strobeRise = !strobeActive && strobePrev_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobePrev_reg <= 1'b0;
        end else begin
            strobePrev_reg <= strobeActive;
        end
    end

    // Nonmux bit overrides fullword bit
    always_comb begin
        if (nonmuxModeBit) begin
            mode = HAP_MODE_NONMUX;
        end else if (fullwordModeBit) begin
            mode = HAP_MODE_MUX_FULL;
        end else begin
            mode = HAP_MODE_MUX_HALF;
        end
    end

    // Page base replaces the upper half when restricted or nonmux
    function automatic logic [31:0] hapAddr(input logic [15:0] pins, input hap_mode_t m,
                                            input logic page, input logic [31:0] a,
                                            input logic [15:0] base);
        if (m == HAP_MODE_NONMUX) begin
            hapAddr = {base, pins};
        end else if (page) begin
            hapAddr = {base, a[15:0]};
        end else begin
            hapAddr = a;
        end
    endfunction

    // Half mode returns the selected half in the low pins
    function automatic logic [31:0] hapFmt(input logic [31:0] w, input logic hi,
                                           input logic half);
        hapFmt = half ? {w[31:16], (hi ? w[31:16] : w[15:0])} : w;
    endfunction

    // Type decode; nonmux refuses address and increment types
    assign liveIsData = (typeS == HAP_TYPE_INC) || (typeS == HAP_TYPE_NOINC);
    assign liveOk = !(nonmuxModeBit && (typeS == HAP_TYPE_INC || typeS == HAP_TYPE_ADDR));
    assign latIsData = (typeLat_reg == HAP_TYPE_INC) || (typeLat_reg == HAP_TYPE_NOINC);
    assign latOk = !(nonmuxModeBit &&
                     (typeLat_reg == HAP_TYPE_INC || typeLat_reg == HAP_TYPE_ADDR));

    // Reads fetch on the first half only; second half comes from the buffer
    assign startRead = (state_reg == HAP_ST_IDLE) && strobeFall && rwS && liveIsData &&
                       liveOk && (mode != HAP_MODE_MUX_HALF || !dataS[16]);
    assign wrAct = strobeRise && !rwLat_reg && (mode != HAP_MODE_MUX_HALF || hwilLat_reg);
    assign startWrite = wrAct && (state_reg == HAP_ST_IDLE) && latIsData && latOk;
    assign wrWord = (mode == HAP_MODE_MUX_HALF) ? {dataS[15:0], halfBuf_reg} : dataS;
    assign wrBe = (mode == HAP_MODE_MUX_HALF) ? {beLat_reg[1:0], beBuf_reg} : beLat_reg;

    always_comb begin
        ctrlView = HAP_DATA_RESET;
        ctrlView[HAP_CTRL_CORE_INT_BIT] = coreInt_reg;
        ctrlView[HAP_CTRL_HOST_INT_BIT] = hostInt_reg;
    end

    // Access sequencer
    always_comb begin
        stateNext = state_reg;
        case (state_reg)
            HAP_ST_IDLE: begin
                if (startRead) begin
                    stateNext = HAP_ST_READ;
                end else if (startWrite) begin
                    stateNext = HAP_ST_WRITE;
                end
            end
            HAP_ST_READ, HAP_ST_WRITE: begin
                if (memAck) begin
                    stateNext = HAP_ST_IDLE;
                end
            end
            default: stateNext = HAP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= HAP_ST_IDLE;
        end else begin
            state_reg <= stateNext;
        end
    end

    // Address and control captured when the strobe asserts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            typeLat_reg <= HAP_TYPE_CTRL;
            rwLat_reg <= 1'b1;
            hwilLat_reg <= 1'b0;
            beLat_reg <= HAP_BE4_RESET;
            addrLat_reg <= HAP_HALF_RESET;
        end else if (strobeFall) begin
            typeLat_reg <= typeS;
            rwLat_reg <= rwS;
            hwilLat_reg <= dataS[16];
            beLat_reg <= beS;
            addrLat_reg <= addrPinS;
        end
    end

    // First half of a half-mode write waits here for the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halfBuf_reg <= HAP_HALF_RESET;
            beBuf_reg <= HAP_BE2_RESET;
        end else if (strobeRise && !rwLat_reg && !hwilLat_reg) begin
            halfBuf_reg <= dataS[15:0];
            beBuf_reg <= beLat_reg[1:0];
        end
    end

    // Address register: host loads, incrementing data accesses advance it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            portAddr_reg <= HAP_ADDR_RESET;
        end else if (wrAct && typeLat_reg == HAP_TYPE_ADDR && latOk) begin
            portAddr_reg <= wrWord;
        end else if (state_reg != HAP_ST_IDLE && memAck && typeLat_reg == HAP_TYPE_INC) begin
            portAddr_reg <= portAddr_reg + HAP_WORD_STEP;
        end
    end

    // Memory request held until acknowledged
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memReq_reg <= 1'b0;
            memWrite_reg <= 1'b0;
            memAddr_reg <= HAP_ADDR_RESET;
            memBe_reg <= HAP_BE4_RESET;
            memWdata_reg <= HAP_DATA_RESET;
        end else if (startRead) begin
            memReq_reg <= 1'b1;
            memWrite_reg <= 1'b0;
            memAddr_reg <= hapAddr(addrPinS, mode, pageRestrictBit, portAddr_reg,
                                   {pageAddrTopByte, pageAddrUpperMidByte});
            memBe_reg <= 4'hF;
        end else if (startWrite) begin
            memReq_reg <= 1'b1;
            memWrite_reg <= 1'b1;
            memAddr_reg <= hapAddr(addrLat_reg, mode, pageRestrictBit, portAddr_reg,
                                   {pageAddrTopByte, pageAddrUpperMidByte});
            memBe_reg <= wrBe;
            memWdata_reg <= wrWord;
        end else if (memAck) begin
            memReq_reg <= 1'b0;
        end
    end

    // Read data: registers at once, memory after the fetch returns
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataOut_reg <= HAP_DATA_RESET;
            rdBuf_reg <= HAP_DATA_RESET;
        end else if (state_reg == HAP_ST_READ && memAck) begin
            rdBuf_reg <= memRdata;
            dataOut_reg <= hapFmt(memRdata, 1'b0, mode == HAP_MODE_MUX_HALF);
        end else if (strobeFall && rwS) begin
            if (typeS == HAP_TYPE_CTRL) begin
                dataOut_reg <= hapFmt(ctrlView, dataS[16], mode == HAP_MODE_MUX_HALF);
            end else if (typeS == HAP_TYPE_ADDR && liveOk) begin
                dataOut_reg <= hapFmt(portAddr_reg, dataS[16], mode == HAP_MODE_MUX_HALF);
            end else if (liveIsData && liveOk && mode == HAP_MODE_MUX_HALF && dataS[16]) begin
                dataOut_reg <= hapFmt(rdBuf_reg, 1'b1, 1'b1);
            end else if (!liveOk) begin
                dataOut_reg <= HAP_DATA_RESET;
            end
        end
    end

    // One enable for all 32 pins, even in half mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataOe_reg <= 1'b0;
        end else if (strobeFall && rwS) begin
            dataOe_reg <= 1'b1;
        end else if (strobeRise || csS_b) begin
            dataOe_reg <= 1'b0;
        end
    end

    // Ready falls only while selected; released once idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= csS_b || (stateNext == HAP_ST_IDLE);
        end
    end

    // Interrupt flags; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hostInt_reg <= 1'b0;
            coreInt_reg <= 1'b0;
        end else begin
            if (coreHostIntSet) begin
                hostInt_reg <= 1'b1;
            end else if (wrAct && typeLat_reg == HAP_TYPE_CTRL &&
                         wrWord[HAP_CTRL_HOST_INT_BIT]) begin
                hostInt_reg <= 1'b0;
            end
            if (wrAct && typeLat_reg == HAP_TYPE_CTRL && wrWord[HAP_CTRL_CORE_INT_BIT]) begin
                coreInt_reg <= 1'b1;
            end else if (coreIntClear) begin
                coreInt_reg <= 1'b0;
            end
        end
    end

    assign hostDataOut = dataOut_reg;
    assign hostDataOe = dataOe_reg;
    assign hostReadyOut = ready_reg;
    assign interruptToHost = hostInt_reg;
    assign hostToCoreInt = coreInt_reg;
    assign memReq = memReq_reg;
    assign memWrite = memWrite_reg;
    assign memAddr = memAddr_reg;
    assign memByteEn = memBe_reg;
    assign memWdata = memWdata_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ready_deselect: assert property (csS_b |=> hostReadyOut)
        else $error("ready low while deselected");
    a_ready_busy: assert property (!csS_b && stateNext != HAP_ST_IDLE |=> !hostReadyOut)
        else $error("ready high during operation");
    a_read_fetch: assert property (startRead |=> memReq && !memWrite)
        else $error("read fetch not issued");
    a_req_hold: assert property (memReq && !memAck |=> memReq)
        else $error("memory request dropped before acknowledge");
    a_fetch_bound: assert property (startRead |-> ##[1:1000] (state_reg == HAP_ST_IDLE))
        else $error("read never completed");
    a_oe_on_read: assert property (strobeFall && rwS |=> hostDataOe[*1])
        else $error("data pins not driven on read");
    a_nonmux_addr: assert property (wrAct && nonmuxModeBit && typeLat_reg == HAP_TYPE_ADDR
        |=> $stable(portAddr_reg))
        else $error("address written in nonmux mode");
    a_auto_inc: assert property (state_reg == HAP_ST_READ && memAck &&
        typeLat_reg == HAP_TYPE_INC |=> portAddr_reg == $past(portAddr_reg) + HAP_WORD_STEP)
        else $error("auto increment wrong");
    a_page_addr: assert property (startRead && pageRestrictBit |=>
        memAddr[31:16] == {$past(pageAddrTopByte), $past(pageAddrUpperMidByte)})
        else $error("page upper address not applied");
    a_half_be: assert property (startWrite && mode == HAP_MODE_MUX_HALF |=>
        memByteEn == {$past(beLat_reg[1:0]), $past(beBuf_reg)})
        else $error("half mode byte enables wrong");
    a_host_int: assert property (coreHostIntSet |=> interruptToHost)
        else $error("host interrupt not raised");
    a_strobe_data: assert property (strobeFall |-> !csS_b && dsS != 2'h0 && dsS != 2'h3)
        else $error("strobe active without select");

    c_read: cover property (startRead ##[1:20] memAck);
    c_write: cover property (startWrite ##[1:20] memAck);
    c_inc_run: cover property (startRead && typeS == HAP_TYPE_INC ##[1:40] startRead);
    c_half_second: cover property (strobeFall && rwS && mode == HAP_MODE_MUX_HALF && dataS[16]);
endmodule

// [bench/hap_mem_model.sv]
// Purpose: Memory space model that answers the port's request handshake
// Assumes: One request outstanding; the bench sets the answer latency
// Notes: Read data is scrambled outside the acknowledge cycle
`timescale 1ns/1ps
module hap_mem_model
    import hap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] memByteEn,
    input wire logic [31:0] memWdata,
    input wire logic [7:0] lat,
    output logic memAck,
    output logic [31:0] memRdata,
    output logic [31:0] lastAddr,
    output int nReq
);
    logic [31:0] mem [0:63];
    logic [7:0] waitCnt;

    // Known pattern so that reads can be predicted
    initial begin
        memAck = 1'b0;
        memRdata = 32'h5A5A_5A5A;
        lastAddr = 32'h0000_0000;
        nReq = 0;
        waitCnt = 8'h00;
        for (int i = 0; i < 64; i++) begin
            mem[i] = 32'hC0DE_0000 + 32'(i);
        end
    end

    // Answer after lat waiting cycles; ack blocked in its own cycle to avoid a double answer
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (!rst_b) begin
            waitCnt <= 8'h00;
        end else if (memReq && !memAck) begin
            if (waitCnt == lat) begin
                waitCnt <= 8'h00;
                memAck <= 1'b1;
                lastAddr <= memAddr;
                nReq <= nReq + 1;
                if (memWrite) begin
                    for (int b = 0; b < 4; b++) begin
                        if (memByteEn[b]) begin
                            mem[memAddr[7:2]][8*b+:8] <= memWdata[8*b+:8];
                        end
                    end
                end else begin
                    memRdata <= mem[memAddr[7:2]];
                end
            end else begin
                waitCnt <= waitCnt + 8'h01;
            end
        end
    end
endmodule

// [bench/hap_port_tb.sv]
// Purpose: Self-checking bench for the host access port
// Assumes: Bench plays the host, driving pins at the falling clock edge
// Notes: Host waits on ready after each strobe edge, as the port requires
`timescale 1ns/1ps
module hap_port_tb
    import hap_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hostChipSelect_b = 1'b1;
    logic [1:0] hostDataStrobes = 2'h3;
    logic hostReadWrite = 1'b1;
    logic [1:0] accessTypeSelect = 2'h0;
    logic [3:0] hostByteEnables = 4'hF;
    logic [15:0] hostAddrPins = 16'h0000;
    logic [31:0] hostDataIn = 32'h0000_0000;
    logic coreHostIntSet = 1'b0;
    logic coreIntClear = 1'b0;
    logic nonmuxModeBit = 1'b0;
    logic fullwordModeBit = 1'b1;
    logic pageRestrictBit = 1'b0;
    logic [7:0] pageAddrTopByte = 8'h12;
    logic [7:0] pageAddrUpperMidByte = 8'h34;
    logic [7:0] lat = 8'h00;
    logic [31:0] hostDataOut, memAddr, memWdata, memRdata, lastAddr, q;
    logic hostDataOe, hostReadyOut, interruptToHost, hostToCoreInt, oe;
    logic memReq, memWrite, memAck;
    logic [3:0] memByteEn;
    int nReq;
    int base;
    int n_mismatch = 0;
    int n_checks = 0;

    always #25 clk = ~clk;

    hap_port DUT (.clk, .rst_b, .hostChipSelect_b, .hostDataStrobes, .hostReadWrite,
        .accessTypeSelect, .hostByteEnables, .hostAddrPins, .hostDataIn, .hostDataOut,
        .hostDataOe, .hostReadyOut, .interruptToHost, .hostToCoreInt, .coreHostIntSet,
        .coreIntClear, .nonmuxModeBit, .fullwordModeBit, .pageRestrictBit,
        .pageAddrTopByte, .pageAddrUpperMidByte, .memReq, .memWrite, .memAddr,
        .memByteEn, .memWdata, .memAck, .memRdata);

    hap_mem_model mem0 (.clk, .rst_b, .memReq, .memWrite, .memAddr, .memByteEn,
        .memWdata, .lat, .memAck, .memRdata, .lastAddr, .nReq);

    function automatic logic [31:0] mv(input int i);
        return 32'hC0DE_0000 + 32'(i);
    endfunction

    // Half-word bus value: identifier on bit 16
    function automatic logic [31:0] hw(input logic id, input logic [15:0] v);
        return {15'h0000, id, v};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Bounded wait, since a stuck ready would hang the host
    task automatic waitRdy;
        int n;
        for (n = 0; n < 200 && hostReadyOut !== 1'b1; n++) @(negedge clk);
        chk("ready wait", n < 200, 1'b1);
    endtask

    // One host cycle; read data sampled once ready is back, before strobe release
    task automatic acc(input logic rw, input logic [1:0] ty, input logic [31:0] d,
        input logic [3:0] be = 4'hF);
        @(negedge clk);
        hostReadWrite = rw;
        accessTypeSelect = ty;
        hostByteEnables = be;
        hostDataIn = d;
        hostChipSelect_b = 1'b0;
        hostDataStrobes = 2'h2;
        repeat (6) @(negedge clk);
        waitRdy();
        q = hostDataOut;
        oe = hostDataOe;
        hostDataStrobes = 2'h3;
        repeat (6) @(negedge clk);
        waitRdy();
        hostChipSelect_b = 1'b1;
        hostDataIn = ~d;
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles at most
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        // Idle state after reset
        chk("ready idle", hostReadyOut, 1'b1);
        chk("oe idle", hostDataOe, 1'b0);
        chk("host int idle", interruptToHost, 1'b0);
        chk("core int idle", hostToCoreInt, 1'b0);
        // Fullword mux: address, plain and incrementing data
        acc(1'b0, HAP_TYPE_ADDR, 32'h0000_0010);
        acc(1'b1, HAP_TYPE_NOINC, 32'h0000_0000);
        chk("rd w4", q, mv(4));
        chk("addr w4", lastAddr, 32'h0000_0010);
        acc(1'b0, HAP_TYPE_INC, 32'h1111_2222);
        acc(1'b0, HAP_TYPE_INC, 32'h3333_4444);
        acc(1'b1, HAP_TYPE_ADDR, 32'h0000_0000);
        chk("addr after run", q, 32'h0000_0018);
        chk("mem w4", mem0.mem[4], 32'h1111_2222);
        chk("mem w5", mem0.mem[5], 32'h3333_4444);
        acc(1'b1, HAP_TYPE_INC, 32'h0000_0000);
        chk("rd w6", q, mv(6));
        acc(1'b1, HAP_TYPE_NOINC, 32'h0000_0000);
        chk("rd w7", q, mv(7));
        acc(1'b0, HAP_TYPE_NOINC, 32'hAABB_CCDD, 4'h5);
        acc(1'b1, HAP_TYPE_NOINC, 32'h0000_0000);
        chk("be w7", q, 32'hC0BB_00DD);
        // Interrupts in both directions
        acc(1'b0, HAP_TYPE_CTRL, 32'h0000_0002);
        chk("core int set", hostToCoreInt, 1'b1);
        @(negedge clk) coreIntClear = 1'b1;
        @(negedge clk) coreIntClear = 1'b0;
        chk("core int clr", hostToCoreInt, 1'b0);
        @(negedge clk) coreHostIntSet = 1'b1;
        @(negedge clk) coreHostIntSet = 1'b0;
        chk("host int set", interruptToHost, 1'b1);
        acc(1'b1, HAP_TYPE_CTRL, 32'h0000_0000);
        chk("ctrl rd", q, 32'h0000_0004);
        acc(1'b0, HAP_TYPE_CTRL, 32'h0000_0004);
        chk("host int clr", interruptToHost, 1'b0);
        // No access without select, none with equal strobes
        base = nReq;
        accessTypeSelect = HAP_TYPE_NOINC;
        hostDataStrobes = 2'h2;
        repeat (8) @(negedge clk);
        hostChipSelect_b = 1'b0;
        hostDataStrobes = 2'h0;
        repeat (8) @(negedge clk);
        chk("no strobe req", nReq, base);
        chk("no strobe oe", hostDataOe, 1'b0);
        hostChipSelect_b = 1'b1;
        hostDataStrobes = 2'h3;
        // Slow memory: ready held low, released by deselect
        lat = 8'h1E;
        @(negedge clk);
        hostReadWrite = 1'b1;
        hostChipSelect_b = 1'b0;
        hostDataStrobes = 2'h2;
        repeat (8) @(negedge clk);
        chk("ready busy", hostReadyOut, 1'b0);
        chk("req busy", memReq, 1'b1);
        hostChipSelect_b = 1'b1;
        hostDataStrobes = 2'h3;
        repeat (4) @(negedge clk);
        chk("ready desel", hostReadyOut, 1'b1);
        repeat (40) @(negedge clk);
        lat = 8'h03;
        // Page override of the upper address half
        pageRestrictBit = 1'b1;
        acc(1'b0, HAP_TYPE_ADDR, 32'hABCD_0020);
        acc(1'b1, HAP_TYPE_NOINC, 32'h0000_0000);
        chk("page addr", lastAddr, 32'h1234_0020);
        chk("page rd", q, mv(8));
        pageRestrictBit = 1'b0;
        // Nonmux: address from pins, only two access types
        nonmuxModeBit = 1'b1;
        hostAddrPins = 16'h0024;
        acc(1'b1, HAP_TYPE_NOINC, 32'h0000_0000);
        chk("nonmux_mode_bit addr", lastAddr, 32'h1234_0024);
        chk("nonmux_mode_bit rd", q, mv(9));
        base = nReq;
        acc(1'b1, HAP_TYPE_INC, 32'h0000_0000);
        chk("nonmux_mode_bit inc rd", q, 32'h0000_0000);
        chk("nonmux_mode_bit inc req", nReq, base);
        acc(1'b0, HAP_TYPE_ADDR, 32'h0000_0040);
        nonmuxModeBit = 1'b0;
        acc(1'b1, HAP_TYPE_ADDR, 32'h0000_0000);
        chk("nonmux_mode_bit addr kept", q, 32'hABCD_0020);
        // Half-word mux: two halves per word, upper enables off
        fullwordModeBit = 1'b0;
        acc(1'b0, HAP_TYPE_ADDR, hw(1'b0, 16'h0030), 4'h3);
        acc(1'b0, HAP_TYPE_ADDR, hw(1'b1, 16'h0000), 4'h3);
        acc(1'b0, HAP_TYPE_NOINC, hw(1'b0, 16'hBEEF), 4'h3);
        acc(1'b0, HAP_TYPE_NOINC, hw(1'b1, 16'hCAFE), 4'h3);
        chk("half wr", mem0.mem[12], 32'hCAFE_BEEF);
        // Upper enables alone must not let any byte through
        acc(1'b0, HAP_TYPE_NOINC, hw(1'b0, 16'h1111), 4'hC);
        acc(1'b0, HAP_TYPE_NOINC, hw(1'b1, 16'h2222), 4'hC);
        chk("half be off", mem0.mem[12], 32'hCAFE_BEEF);
        acc(1'b1, HAP_TYPE_NOINC, hw(1'b0, 16'h0000), 4'h3);
        chk("half rd lo", q[15:0], 16'hBEEF);
        chk("half rd hi", q[31:16], 16'hCAFE);
        chk("half oe", oe, 1'b1);
        acc(1'b1, HAP_TYPE_NOINC, hw(1'b1, 16'h0000), 4'h3);
        chk("half rd 2nd", q[15:0], 16'hCAFE);
        report_and_stop();
    end
endmodule
